/* File: shared/slar_pkg.sv */
// Register map, field layout and reset values of the limit and alert bank.
package slar_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0]  ADDR_CH2_CRIT  = 8'h09;
    localparam logic [7:0]  ADDR_CH2_WARN  = 8'h0a;
    localparam logic [7:0]  ADDR_CH3_CRIT  = 8'h0b;
    localparam logic [7:0]  ADDR_CH3_WARN  = 8'h0c;
    localparam logic [7:0]  ADDR_TOTAL     = 8'h0d;
    localparam logic [7:0]  ADDR_TOTAL_LIM = 8'h0e;
    localparam logic [7:0]  ADDR_CTRL      = 8'h0f;

    // ==========================================================
    // Reset values
    localparam logic [15:0] LIMIT_RST      = 16'h7ff8;
    localparam logic [15:0] TOTAL_RST      = 16'h0000;
    localparam logic [15:0] TOTAL_LIM_RST  = 16'h7ffe;
    localparam logic [15:0] CTRL_RST       = 16'h0002;

    // ==========================================================
    // Field positions
    localparam int          NUM_CH         = 3;
    localparam int          LIM_MSB        = 15;
    localparam int          LIM_LSB        = 3;
    localparam int          TOT_MSB        = 15;
    localparam int          TOT_LSB        = 1;
    localparam int          CTRL_RSVD      = 15;
    localparam int          CTRL_SUMSEL_HI = 14;
    localparam int          CTRL_SUMSEL_LO = 12;
    localparam int          CTRL_WLATCH    = 11;
    localparam int          CTRL_CLATCH    = 10;
    localparam int          CTRL_CF_HI     = 9;
    localparam int          CTRL_CF_LO     = 7;
    localparam int          CTRL_SF        = 6;
    localparam int          CTRL_WF_HI     = 5;
    localparam int          CTRL_WF_LO     = 3;
    localparam int          CTRL_PVF       = 2;
    localparam int          CTRL_TCF       = 1;
    localparam int          CTRL_CONVERSION_READY_FLAG      = 0;

    // Weight of one total step in microvolts.
    localparam int          TOTAL_LSB_UV   = 40;

endpackage : slar_pkg

/* File: hdl/slar_regs.sv */
// Channel 2/3 limits, shunt total, total limit and alert control register.
`timescale 1ns/1ns

// Contract
// - Warning limit is compared with each averaged shunt result of that channel.
// - Critical limit is compared with every single shunt conversion of channel.
// - Limit registers hold 16 bits, limit in 15:3, reset 7FF8h.
// - Channel-2 warning at 0Ah, channel-3 critical 0Bh, channel-3 warning 0Ch.
// - Total adds single conversions only of channels selected by bits 14:12.
// - Total register updates only after a full cycle; step is 40 uV.
// - Total register is read-only signed, value in 15:1, resets zero, at 0Dh.
// - After each full cycle the total is compared with the total limit.
// - Total limit at 0Eh, signed value in 15:1, resets to 7FFEh.
// - Control register chooses alert sources and how each alert responds.
// - Reading the control register clears the critical, warning and summation flags set in it.
// - Writing the control register changes only settings, never flags.
// - Control register at 0Fh resets 0002h with the documented bit layout.
// - Exceeding critical or warning limit sets flag and asserts its alert.
// - Total above total limit sets summation flag and asserts critical alert.
// - Latch bit 0 gives transparent alert, 1 latched; both reset transparent.
// - Ready flag sets on conversions done, clears on read or config write.
module slar_regs (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        shunt_vld,
    input  wire logic [1:0]  shunt_ch,
    input  wire logic [15:0] shunt_data,
    input  wire logic        avg_vld,
    input  wire logic [1:0]  avg_ch,
    input  wire logic [15:0] avg_data,
    input  wire logic        sum_cycle_done,
    input  wire logic        conv_done,
    input  wire logic        cfg_wr_clr,
    input  wire logic [15:0] ch1_crit_limit,
    input  wire logic [15:0] ch1_warn_limit,
    input  wire logic        pv_alert,
    input  wire logic        tc_alert,
    output logic             crit_alert_n,
    output logic             warn_alert_n
);
    import slar_pkg::*;

    // ==========================================================
    // State
    logic [15:0]       crit_lim_r [1:2], crit_lim_nxt [1:2];
    logic [15:0]       warn_lim_r [1:2], warn_lim_nxt [1:2];
    logic [15:0]       tot_lim_r;
    logic [15:0]       total_r, total_nxt;
    logic [14:0]       acc_r, acc_nxt;
    logic [5:0]        ctrl_cfg_r, ctrl_cfg_nxt;
    logic [2:0]        cf_r, cf_nxt;
    logic [2:0]        wf_r, wf_nxt;
    logic              sf_r, sf_nxt;
    logic              conversion_ready_flag_r, conversion_ready_flag_nxt;
    logic              tcf_r, tcf_nxt;
    logic              pvf_r;
    logic [2:0]        cst_r, cst_nxt;
    logic [2:0]        wst_r, wst_nxt;
    logic              sst_r, sst_nxt;
    logic [15:0]       rdata_r, rdata_nxt;
    logic              crit_n_r, crit_n_nxt;
    logic              warn_n_r, warn_n_nxt;

    logic [15:0]       crit_lim [0:2];
    logic [15:0]       warn_lim [0:2];
    logic [2:0]        crit_gt;
    logic [2:0]        warn_gt;
    logic [2:0]        crit_hit;
    logic [2:0]        warn_hit;
    logic [2:0]        sum_sel;
    logic [14:0]       acc_sum;
    logic              sum_gt;
    logic              sum_hit;
    logic              rd_ctrl;
    logic [15:0]       ctrl_view;

    // Bit 14 selects channel 1, so the field is taken in reverse.
    assign sum_sel = {ctrl_cfg_r[2], ctrl_cfg_r[3], ctrl_cfg_r[4]};
    assign rd_ctrl = reg_rd && (reg_addr == ADDR_CTRL);
    assign crit_lim = '{ch1_crit_limit, crit_lim_r[1], crit_lim_r[2]};
    assign warn_lim = '{ch1_warn_limit, warn_lim_r[1], warn_lim_r[2]};

    // ==========================================================
    // Per-channel limit comparison
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_cmp
            // Signed, same weight, strictly greater.
            assign crit_gt[gi] = $signed(shunt_data[LIM_MSB:LIM_LSB]) >
                                 $signed(crit_lim[gi][LIM_MSB:LIM_LSB]);
            assign warn_gt[gi] = $signed(avg_data[LIM_MSB:LIM_LSB]) >
                                 $signed(warn_lim[gi][LIM_MSB:LIM_LSB]);
            // Every single conversion is checked.
            assign crit_hit[gi] = shunt_vld && (shunt_ch == 2'(gi)) &&
                                  crit_gt[gi];
            // Only averaged results are checked.
            assign warn_hit[gi] = avg_vld && (avg_ch == 2'(gi)) &&
                                  warn_gt[gi];
        end
    endgenerate

    // ==========================================================
    // Shunt total accumulation and its limit check
    always_comb begin
        acc_sum = acc_r;
        if (shunt_vld && (shunt_ch < 2'(NUM_CH)) && sum_sel[shunt_ch]) begin
            // Only selected channels contribute.
            acc_sum = acc_r + {{2{shunt_data[15]}},
                               shunt_data[LIM_MSB:LIM_LSB]};
        end
    end

    // Total is checked once per completed cycle.
    assign sum_gt  = $signed(acc_sum) > $signed(tot_lim_r[TOT_MSB:TOT_LSB]);
    assign sum_hit = sum_cycle_done && sum_gt;

    always_comb begin
        acc_nxt   = acc_sum;
        total_nxt = total_r;
        if (sum_cycle_done) begin
            // Newest total is published only at cycle end.
            total_nxt = {acc_sum, 1'b0};
            acc_nxt   = '0;
        end
    end

    // ==========================================================
    // Register writes
    always_comb begin
        crit_lim_nxt = crit_lim_r;
        warn_lim_nxt = warn_lim_r;
        ctrl_cfg_nxt = ctrl_cfg_r;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CH2_CRIT: crit_lim_nxt[1] = reg_wdata;
                ADDR_CH2_WARN: warn_lim_nxt[1] = reg_wdata;
                ADDR_CH3_CRIT: crit_lim_nxt[2] = reg_wdata;
                ADDR_CH3_WARN: warn_lim_nxt[2] = reg_wdata;
                // Only settings are taken, flag bits are dropped.
                ADDR_CTRL:     ctrl_cfg_nxt =
                                   reg_wdata[CTRL_RSVD:CTRL_CLATCH];
                default:       ctrl_cfg_nxt = ctrl_cfg_r;
            endcase
        end
    end

    // ==========================================================
    // Flags and transparent status
    always_comb begin
        // A new event in the clearing cycle wins over the clear.
        cf_nxt   = (rd_ctrl ? 3'h0 : cf_r) | crit_hit;
        wf_nxt   = (rd_ctrl ? 3'h0 : wf_r) | warn_hit;
        sf_nxt   = (rd_ctrl ? 1'b0 : sf_r) | sum_hit;
        conversion_ready_flag_nxt = ((rd_ctrl || cfg_wr_clr) ? 1'b0 : conversion_ready_flag_r) |
                   conv_done;
        tcf_nxt  = tcf_r | tc_alert;
        cst_nxt  = cst_r;
        wst_nxt  = wst_r;
        sst_nxt  = sst_r;
        for (int i = 0; i < NUM_CH; i++) begin
            if (shunt_vld && (shunt_ch == 2'(i))) begin
                cst_nxt[i] = crit_gt[i];
            end
            if (avg_vld && (avg_ch == 2'(i))) begin
                wst_nxt[i] = warn_gt[i];
            end
        end
        if (sum_cycle_done) begin
            sst_nxt = sum_gt;
        end
    end

    // ==========================================================
    // Alert outputs, active low
    always_comb begin
        // Latch bit picks held flags or the latest comparison.
        if (ctrl_cfg_r[CTRL_CLATCH - CTRL_CLATCH]) begin
            crit_n_nxt = ~(|cf_nxt || sf_nxt);
        end else begin
            crit_n_nxt = ~(|cst_nxt || sst_nxt);
        end
        if (ctrl_cfg_r[CTRL_WLATCH - CTRL_CLATCH]) begin
            warn_n_nxt = ~(|wf_nxt);
        end else begin
            warn_n_nxt = ~(|wst_nxt);
        end
    end

    // ==========================================================
    // Read data
    // Control view in its documented layout.
    assign ctrl_view = {ctrl_cfg_r, cf_r[0], cf_r[1], cf_r[2], sf_r,
                        wf_r[0], wf_r[1], wf_r[2], pvf_r, tcf_r, conversion_ready_flag_r};

    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CH2_CRIT:  rdata_nxt = crit_lim_r[1];
                ADDR_CH2_WARN:  rdata_nxt = warn_lim_r[1];
                ADDR_CH3_CRIT:  rdata_nxt = crit_lim_r[2];
                ADDR_CH3_WARN:  rdata_nxt = warn_lim_r[2];
                ADDR_TOTAL:     rdata_nxt = total_r;
                ADDR_TOTAL_LIM: rdata_nxt = tot_lim_r;
                ADDR_CTRL:      rdata_nxt = ctrl_view;
                default:        rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            crit_lim_r    <= '{default: LIMIT_RST};
            warn_lim_r    <= '{default: LIMIT_RST};
            tot_lim_r     <= TOTAL_LIM_RST;
            total_r       <= TOTAL_RST;
            acc_r         <= '0;
            ctrl_cfg_r    <= CTRL_RST[CTRL_RSVD:CTRL_CLATCH];
            cf_r          <= CTRL_RST[CTRL_CF_HI:CTRL_CF_LO];
            wf_r          <= CTRL_RST[CTRL_WF_HI:CTRL_WF_LO];
            sf_r          <= CTRL_RST[CTRL_SF];
            conversion_ready_flag_r        <= CTRL_RST[CTRL_CONVERSION_READY_FLAG];
            tcf_r         <= CTRL_RST[CTRL_TCF];
            pvf_r         <= CTRL_RST[CTRL_PVF];
            cst_r         <= '0;
            wst_r         <= '0;
            sst_r         <= 1'b0;
            rdata_r       <= 16'h0000;
            crit_n_r      <= 1'b1;
            warn_n_r      <= 1'b1;
        end else begin
            crit_lim_r    <= crit_lim_nxt;
            warn_lim_r    <= warn_lim_nxt;
            total_r       <= total_nxt;
            acc_r         <= acc_nxt;
            ctrl_cfg_r    <= ctrl_cfg_nxt;
            cf_r          <= cf_nxt;
            wf_r          <= wf_nxt;
            sf_r          <= sf_nxt;
            conversion_ready_flag_r        <= conversion_ready_flag_nxt;
            tcf_r         <= tcf_nxt;
            pvf_r         <= pv_alert;
            cst_r         <= cst_nxt;
            wst_r         <= wst_nxt;
            sst_r         <= sst_nxt;
            rdata_r       <= rdata_nxt;
            crit_n_r      <= crit_n_nxt;
            warn_n_r      <= warn_n_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign crit_alert_n = crit_n_r;
    assign warn_alert_n = warn_n_r;

    // ==========================================================
    // Assertions
    sequence s_ctrl_read;
        reg_rd && reg_addr == ADDR_CTRL && !(|crit_hit) && !sum_hit;
    endsequence

    sequence s_flags_gone;
        cf_r == 3'h0 && !sf_r;
    endsequence

    property p_rd_clears;
        @(posedge ref_clk) disable iff (sys_rst)
        s_ctrl_read |=> s_flags_gone;
    endproperty
    a_rd_clears: assert property (p_rd_clears)
        else $error("control read did not clear critical flags");

    property p_wr_keeps_flags;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == ADDR_CTRL && !reg_rd && !(|warn_hit)
        |=> wf_r == $past(wf_r) && ctrl_cfg_r == $past(reg_wdata[15:10]);
    endproperty
    a_wr_keeps_flags: assert property (p_wr_keeps_flags)
        else $error("control write disturbed warning flags");

    property p_crit_sets;
        @(posedge ref_clk) disable iff (sys_rst)
        shunt_vld && shunt_ch == 2'd2 &&
        $signed(shunt_data[15:3]) > $signed(crit_lim_r[2][15:3])
        |=> cf_r[2] && !crit_alert_n;
    endproperty
    a_crit_sets: assert property (p_crit_sets)
        else $error("critical overrun on channel 3 not flagged");
    property p_warn_sets;
        @(posedge ref_clk) disable iff (sys_rst)
        avg_vld && avg_ch == 2'd1 &&
        $signed(avg_data[15:3]) > $signed(warn_lim_r[1][15:3])
        |=> wf_r[1] && !warn_alert_n;
    endproperty
    a_warn_sets: assert property (p_warn_sets)
        else $error("warning overrun on channel 2 not flagged");
    property p_total_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !sum_cycle_done |=> total_r == $past(total_r);
    endproperty
    a_total_hold: assert property (p_total_hold)
        else $error("total changed outside a cycle end");
    property p_total_lsb;
        @(posedge ref_clk) disable iff (sys_rst)
        total_r[0] == 1'b0 && tot_lim_r == TOTAL_LIM_RST;
    endproperty
    a_total_lsb: assert property (p_total_lsb)
        else $error("total reserved bit or total limit wrong");
    property p_sum_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        sum_hit |=> sf_r && !crit_alert_n;
    endproperty
    a_sum_flag: assert property (p_sum_flag)
        else $error("total overrun did not raise critical alert");
    property p_transparent;
        @(posedge ref_clk) disable iff (sys_rst)
        !ctrl_cfg_r[1] && !(|wst_nxt) |=> warn_alert_n;
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("transparent warning alert stayed low");
    property p_ready;
        @(posedge ref_clk) disable iff (sys_rst)
        conv_done |=> conversion_ready_flag_r ##1 (conversion_ready_flag_r || $past(rd_ctrl) || $past(cfg_wr_clr));
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready flag wrong after conversions");

endmodule : slar_regs

/* File: tb/slar_host.sv */
// Host model driving the register port of the limit and alert bank.
`timescale 1ns/1ns
module slar_host (
    input  wire logic        ref_clk,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd    = 1'b0;
    end

    // ==========================================================
    // Register cycles
    // Write data is inverted once released so stale data never looks valid.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd
endmodule : slar_host

/* File: tb/slar_regs_tb.sv */
// Self-checking bench for the limit and alert register bank.
`timescale 1ns/1ns
module slar_regs_tb;
    import slar_pkg::*;

    logic        ref_clk, sys_rst;
    logic [7:0]  reg_addr;
    logic        reg_wr, reg_rd;
    logic [15:0] reg_wdata, reg_rdata;
    logic        shunt_vld = 1'b0, avg_vld = 1'b0;
    logic [1:0]  shunt_ch = 2'h0, avg_ch = 2'h0;
    logic [15:0] shunt_data = 16'h0000, avg_data = 16'h0000;
    logic        sum_cycle_done = 1'b0, conv_done = 1'b0;
    logic        cfg_wr_clr = 1'b0, pv_alert = 1'b0;
    logic [15:0] lim = 16'h7ff8;
    logic        crit_alert_n, warn_alert_n;
    int          seed = 32'hd3d9;
    int          fail_count = 0;
    int          checks = 0;
    logic [15:0] d, x;
    logic [14:0] s;
    logic [7:0]  addrs [8] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                               8'h0f, 8'h20};
    logic [15:0] rsts [8] = '{16'h7ff8, 16'h7ff8, 16'h7ff8, 16'h7ff8,
                              16'h0000, 16'h7ffe, 16'h0002, 16'h0000};
    logic [15:0] sels [3] = '{16'h5000, 16'h7000, 16'h2000};

    slar_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    slar_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shunt_vld(shunt_vld),
        .shunt_ch(shunt_ch), .shunt_data(shunt_data), .avg_vld(avg_vld),
        .avg_ch(avg_ch), .avg_data(avg_data),
        .sum_cycle_done(sum_cycle_done), .conv_done(conv_done),
        .cfg_wr_clr(cfg_wr_clr), .ch1_crit_limit(lim),
        .ch1_warn_limit(lim), .pv_alert(pv_alert), .tc_alert(1'b0),
        .crit_alert_n(crit_alert_n), .warn_alert_n(warn_alert_n));

    // ==========================================================
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        final_report();
    end

    // ==========================================================
    // Helpers
    function automatic logic [15:0] flag_bit(input int k, input int c);
        return 16'h0001 << (k ? 5 - c : 9 - c);
    endfunction : flag_bit

    function automatic logic [15:0] ctrl_exp(input logic [15:0] set);
        return (set & 16'hfc00) | 16'h0002;
    endfunction : ctrl_exp

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic meas(input int k, input int c, input logic [15:0] v);
        @(negedge ref_clk);
        if (k == 0) begin
            shunt_vld  = 1'b1;
            shunt_ch   = c[1:0];
            shunt_data = v;
        end else begin
            avg_vld  = 1'b1;
            avg_ch   = c[1:0];
            avg_data = v;
        end
        @(negedge ref_clk);
        shunt_vld  = 1'b0;
        avg_vld    = 1'b0;
        shunt_data = ~shunt_data;
        avg_data   = ~avg_data;
    endtask : meas

    function automatic logic alert(input int k);
        return k ? warn_alert_n : crit_alert_n;
    endfunction : alert

    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            host.rd(addrs[i], d);
            check(d, rsts[i]);
        end
        for (int i = 0; i < 4; i++) begin
            x = 16'($random(seed));
            host.wr(addrs[i], x);
            host.rd(addrs[i], d);
            check(d, x);
        end
        lim = {3'b000, 10'($random(seed)), 3'b000} + 16'h0400;
        for (int i = 0; i < 4; i++) begin
            host.wr(addrs[i], lim);
        end
        // Equal is not over; one step above sets the flag.
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 2; k++) begin
                meas(k, c, lim);
                check(16'(alert(k)), 16'h0001);
                meas(k, c, lim + 16'h0008);
                check(16'(alert(k)), 16'h0000);
                host.rd(ADDR_CTRL, d);
                check(d, ctrl_exp(16'h0) | flag_bit(k, c));
                meas(k, c, lim - 16'h0008);
                check(16'(alert(k)), 16'h0001);
            end
        end
        host.rd(ADDR_CTRL, d);
        host.wr(ADDR_CTRL, 16'h0c00);
        meas(0, 1, lim + 16'h0008);
        meas(0, 1, lim - 16'h0008);
        check(16'(crit_alert_n), 16'h0000);
        meas(1, 1, lim + 16'h0008);
        meas(1, 1, lim - 16'h0008);
        check(16'(warn_alert_n), 16'h0000);
        host.wr(ADDR_CTRL, 16'h0c00);
        x = ctrl_exp(16'h0c00) | flag_bit(0, 1) | flag_bit(1, 1);
        host.rd(ADDR_CTRL, d);
        check(d, x);
        check(16'(crit_alert_n), 16'h0001);
        check(16'(warn_alert_n), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            host.wr(ADDR_CTRL, sels[i]);
            s = 15'h0000;
            for (int c = 0; c < 3; c++) begin
                x = 16'($random(seed));
                if (sels[i][14 - c]) begin
                    s = s + {{2{x[12]}}, x[12:0]};
                end
                meas(0, c, {x[12:0], 3'b000});
            end
            @(negedge ref_clk);
            sum_cycle_done = 1'b1;
            @(negedge ref_clk);
            sum_cycle_done = 1'b0;
            host.rd(ADDR_TOTAL, d);
            check(d, {s, 1'b0});
        end
        host.wr(ADDR_TOTAL, 16'hffff);
        host.rd(ADDR_TOTAL, d);
        check(d, {s, 1'b0});
        host.wr(ADDR_TOTAL_LIM, 16'h0000);
        host.rd(ADDR_TOTAL_LIM, d);
        check(d, 16'h7ffe);
        host.rd(ADDR_CTRL, d);
        pv_alert  = 1'b1;
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
        host.rd(ADDR_CTRL, d);
        check(d, 16'h2007);
        host.rd(ADDR_CTRL, d);
        check(d, 16'h2006);
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done  = 1'b0;
        cfg_wr_clr = 1'b1;
        pv_alert   = 1'b0;
        @(negedge ref_clk);
        cfg_wr_clr = 1'b0;
        host.rd(ADDR_CTRL, d);
        check(d, 16'h2002);
        final_report();
    end
endmodule : slar_regs_tb
